// ### hw/tdm_port_defines.vh
/*
  Constants shared by the shared-frame audio port: field positions,
  register offsets, reset values and frame-sync timing counts.
  Assumes it is included by its bare name by the port design file only.
*/
// Overview of operation
// - Two successive two-clock sync pulses enter shared mode.
// - Assign flag set: frame only assigns IDs.
// - Extended flag: extended packets follow, no audio.
// - Device ID is five bits, 28:24.
// - Chain head takes ID 1, then onward.
// - Token input tied high means ID 1.
// - Broadcast ID 0x1F accepted on writes.
// - ID 0x00 selects nobody; no action.
// - Bit 23 high reads, low writes.
// - Register identifier is seven bits, 22:16.
// - Register data is eight bits, 15:8.
// - Lowest byte ignored, never sent back.
// - Extended field decodes alike, bit 31 reserved.
// - Audio field 32 bits, MSB first, 24-bit.
// - Channel-off register and acquired ID register.
// - Read data shifted out in data phase.
// - Sample input rising, drive output falling.
// - Enable read driver one clock early.
// - Token out high in last own channel.
// - No active channel: pass token straight through.
`ifndef TDM_PORT_DEFINES_VH
`define TDM_PORT_DEFINES_VH

`define ASSIGN_FLAG_POS 31
`define EXT_FLAG_POS    30
`define CHAIN_SEL_POS   29
`define DEV_ID_HI       28
`define DEV_ID_LO       24
`define READ_FLAG_POS   23
`define REG_ID_HI       22
`define REG_ID_LO       16
`define REG_DATA_HI     15
`define REG_DATA_LO     8
`define SAMPLE_HI       31
`define SAMPLE_LO       8

`define CHAN_CTRL_ADDR  7'h13
`define CHAIN_ID_ADDR   7'h17
`define CHAN_CTRL_RST   8'h00
`define CHAN_OFF_POS    0

`define BROADCAST_ID    5'h1f
`define NO_DEVICE_ID    5'h00
`define FIRST_ID        5'h01
`define LAST_ID_SLOT    5'h1d

`define SYNC_PULSE_BITS 3'h2
`define SYNC_CNT_MAX    3'h7
`define FRAMES_TO_ENTER 2'h2

`define FIELD_LAST_BIT  5'h1f
`define RD_ENABLE_BIT   5'h0f
`define RD_FIRST_BIT    5'h10
`define RD_LAST_BIT     5'h17
`define RD_RELEASE_BIT  5'h18

`endif

// ### hw/input_sync.v
/*
  Two-flop synchroniser for the four link pins.
  Assumes the pins are asynchronous to the reference clock.
*/
`timescale 1ns/1ps
module input_sync (
  input  wire       ref_clk_i, // Reference clock.
  input  wire       arst_n_i,  // Asynchronous reset, active low.
  input  wire [3:0] async_i,   // Raw pin levels.
  input  wire [3:0] unused_i,  // Tied low; keeps port groups aligned.
  output reg  [3:0] sync_o     // Synchronised levels.
);

  reg [3:0] meta_reg;

  // First stage feeds only the second stage.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 4'h0;
      sync_o   <= 4'h0;
    end else begin
      meta_reg <= async_i | unused_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // input_sync

// ### hw/bit_clock_edges.v
/*
  Edge finder for the synchronised bit clock.
  Assumes its input has already passed the synchroniser.
*/
`timescale 1ns/1ps
module bit_clock_edges (
  input  wire ref_clk_i, // Reference clock.
  input  wire arst_n_i,  // Asynchronous reset, active low.
  input  wire level_i,   // Synchronised bit clock.
  output wire rise_o,    // One-cycle pulse on a rising edge.
  output wire fall_o     // One-cycle pulse on a falling edge.
);

  reg prev_reg;

  // Previous level, compared with the present one.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
    end
  end

  // Edge pulses.
  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;

endmodule // bit_clock_edges

// ### hw/tdm_command_audio_port.v
/*
  Receive port for the shared command-and-audio serial frame: frame
  mode detection, command decode, chain ID acquisition, register read
  back, token passing and capture of two 24-bit audio channels.
  Assumes all link pins are asynchronous and that the bit clock is far
  slower than the reference clock (at least eight reference cycles).
*/
`timescale 1ns/1ps
`include "tdm_port_defines.vh"
module tdm_command_audio_port (
  input  wire        ref_clk_i,          // 40 MHz reference clock.
  input  wire        arst_n_i,           // Asynchronous reset, low.
  input  wire        frame_sync_i,       // Frame sync pin.
  input  wire        bit_clock_i,        // Bit clock pin.
  input  wire        frame_serial_in_i,  // Serial command/audio in.
  input  wire        chain_token_in_i,   // Chain token from upstream.
  input  wire [7:0]  reg_rdata_i,        // Read data, other registers.
  output reg         cmd_read_o,         // Read-back data out.
  output reg         cmd_read_oe_n_o,    // Low while driving read out.
  output reg         chain_token_out_o,  // Chain token downstream.
  output reg         shared_mode_o,      // Shared-frame mode active.
  output reg  [23:0] audio_left_o,       // First channel sample.
  output reg  [23:0] audio_right_o,      // Second channel sample.
  output reg         audio_valid_o,      // Pulse: sample pair ready.
  output reg         reg_wr_o,           // Pulse: other-register write.
  output reg  [6:0]  reg_addr_o,         // Register identifier.
  output reg  [7:0]  reg_wdata_o,        // Register write data.
  output reg  [7:0]  chan_ctrl_o,        // Channel enable register.
  output reg  [7:0]  chain_id_o          // Acquired chain ID.
);

  localparam [2:0] K_IDLE   = 3'h0;
  localparam [2:0] K_CMD    = 3'h1;
  localparam [2:0] K_EXT    = 3'h2;
  localparam [2:0] K_AUDIO  = 3'h3;
  localparam [2:0] K_IDSLOT = 3'h4;

  wire [3:0] pins_s;
  wire       fs_s;
  wire       bck_s;
  wire       din_s;
  wire       tok_s;
  wire       bck_rise;
  wire       bck_fall;

  reg  [4:0]  bit_cnt_reg;
  reg  [4:0]  field_idx_reg;
  reg  [31:0] sr_reg;
  reg  [2:0]  kind_reg;
  reg         fs_prev_reg;
  reg  [2:0]  fs_hi_cnt_reg;
  reg  [1:0]  fs_good_reg;
  reg  [4:0]  my_id_reg;
  reg         id_valid_reg;
  reg         mine_reg;
  reg         ch_idx_reg;
  reg         chans_done_reg;
  reg         rd_active_reg;
  reg  [7:0]  dq_reg;
  reg         tok_next;

  // Returns one when a command header selects this device.
  function is_sel;
    input       chain_sel;
    input [4:0] id;
    input       rd;
    input [4:0] own_id;
    input       own_valid;
    begin
      is_sel = ~chain_sel
             & (id != `NO_DEVICE_ID)
             & ((own_valid & (id == own_id))
             | ((id == `BROADCAST_ID) & ~rd));
    end
  endfunction

  // Read-back source for a register identifier.
  function [7:0] read_mux;
    input [6:0] addr;
    input [7:0] ctrl;
    input [4:0] own_id;
    input [7:0] other;
    begin
      if (addr == `CHAN_CTRL_ADDR) begin
        read_mux = ctrl;
      end else if (addr == `CHAIN_ID_ADDR) begin
        read_mux = {3'h0, own_id};
      end else begin
        read_mux = other;
      end
    end
  endfunction

  // All four pins pass two flops before any logic reads them.
  input_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({chain_token_in_i, frame_serial_in_i,
                 bit_clock_i, frame_sync_i}),
    .unused_i  (4'h0),
    .sync_o    (pins_s)
  );

  assign fs_s  = pins_s[0];
  assign bck_s = pins_s[1];
  assign din_s = pins_s[2];
  assign tok_s = pins_s[3];

  bit_clock_edges u_edges (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .level_i   (bck_s),
    .rise_o    (bck_rise),
    .fall_o    (bck_fall)
  );

  wire        fs_start = fs_s & ~fs_prev_reg;
  wire [31:0] word     = {sr_reg[30:0], din_s};
  wire        chans_on = ~chan_ctrl_o[`CHAN_OFF_POS];
  wire        field_end = bck_rise & ~fs_start
                        & (bit_cnt_reg == `FIELD_LAST_BIT);
  wire        cmd_like = ((kind_reg == K_CMD) & ~word[`ASSIGN_FLAG_POS])
                       | (kind_reg == K_EXT);
  wire        wr_hit   = is_sel(word[`CHAIN_SEL_POS],
                                word[`DEV_ID_HI:`DEV_ID_LO],
                                word[`READ_FLAG_POS],
                                my_id_reg, id_valid_reg)
                       & ~word[`READ_FLAG_POS];
  wire [6:0]  wr_addr  = word[`REG_ID_HI:`REG_ID_LO];

  // Frame sync pulse length decides whether shared mode is on.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fs_prev_reg   <= 1'b0;
      fs_hi_cnt_reg <= 3'h0;
      fs_good_reg   <= 2'h0;
      shared_mode_o <= 1'b0;
    end else if (bck_rise) begin
      fs_prev_reg <= fs_s;
      if (fs_start) begin
        fs_hi_cnt_reg <= 3'h1;
      end else if (fs_s && fs_hi_cnt_reg != `SYNC_CNT_MAX) begin
        fs_hi_cnt_reg <= fs_hi_cnt_reg + 3'h1;
      end
      if (!fs_s && fs_prev_reg) begin
        if (fs_hi_cnt_reg == `SYNC_PULSE_BITS) begin
          if (fs_good_reg == `FRAMES_TO_ENTER - 2'h1) begin
            shared_mode_o <= 1'b1;
          end
          if (fs_good_reg != `FRAMES_TO_ENTER) begin
            fs_good_reg <= fs_good_reg + 2'h1;
          end
        end else begin
          fs_good_reg   <= 2'h0;
          shared_mode_o <= 1'b0;
        end
      end
    end
  end

  // Serial receive, field sequencing, decode and register writes.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_reg    <= 5'h00;
      field_idx_reg  <= 5'h00;
      sr_reg         <= 32'h0000_0000;
      kind_reg       <= K_IDLE;
      my_id_reg      <= 5'h00;
      id_valid_reg   <= 1'b0;
      mine_reg       <= 1'b0;
      ch_idx_reg     <= 1'b0;
      chans_done_reg <= 1'b0;
      chan_ctrl_o    <= `CHAN_CTRL_RST;
      audio_left_o   <= 24'h00_0000;
      audio_right_o  <= 24'h00_0000;
      audio_valid_o  <= 1'b0;
      reg_wr_o       <= 1'b0;
      reg_addr_o     <= 7'h00;
      reg_wdata_o    <= 8'h00;
    end else begin
      audio_valid_o <= 1'b0;
      reg_wr_o      <= 1'b0;
      if (bck_rise) begin
        sr_reg <= word;
        if (fs_start) begin
          bit_cnt_reg    <= 5'h01;
          field_idx_reg  <= 5'h00;
          kind_reg       <= shared_mode_o ? K_CMD : K_IDLE;
          mine_reg       <= 1'b0;
          chans_done_reg <= 1'b0;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (!fs_start && bit_cnt_reg == `RD_ENABLE_BIT
            && (kind_reg == K_CMD || kind_reg == K_EXT)) begin
          reg_addr_o <= word[6:0];
        end
      end
      if (field_end) begin
        if (field_idx_reg != 5'h1f) begin
          field_idx_reg <= field_idx_reg + 5'h01;
        end
        if (cmd_like && wr_hit) begin
          if (wr_addr == `CHAN_CTRL_ADDR) begin
            chan_ctrl_o <= word[`REG_DATA_HI:`REG_DATA_LO];
          end else if (wr_addr != `CHAIN_ID_ADDR) begin
            reg_wr_o    <= 1'b1;
            reg_addr_o  <= wr_addr;
            reg_wdata_o <= word[`REG_DATA_HI:`REG_DATA_LO];
          end
        end
        case (kind_reg)
          K_CMD: begin
            if (word[`ASSIGN_FLAG_POS]) begin
              kind_reg     <= K_IDSLOT;
              id_valid_reg <= tok_s;
              my_id_reg    <= tok_s ? `FIRST_ID : 5'h00;
            end else if (word[`EXT_FLAG_POS]) begin
              kind_reg <= K_EXT;
            end else begin
              kind_reg <= K_AUDIO;
              if (chans_on && tok_s) begin
                mine_reg   <= 1'b1;
                ch_idx_reg <= 1'b0;
              end
            end
          end
          K_EXT: begin
            kind_reg <= word[`EXT_FLAG_POS] ? K_EXT : K_IDLE;
          end
          K_AUDIO: begin
            if (mine_reg) begin
              if (!ch_idx_reg) begin
                audio_left_o <= word[`SAMPLE_HI:`SAMPLE_LO];
                ch_idx_reg   <= 1'b1;
              end else begin
                audio_right_o  <= word[`SAMPLE_HI:`SAMPLE_LO];
                audio_valid_o  <= 1'b1;
                mine_reg       <= 1'b0;
                chans_done_reg <= 1'b1;
              end
            end else if (!chans_done_reg && chans_on && tok_s) begin
              mine_reg   <= 1'b1;
              ch_idx_reg <= 1'b0;
            end
          end
          K_IDSLOT: begin
            if (!id_valid_reg && tok_s
                && field_idx_reg <= `LAST_ID_SLOT) begin
              my_id_reg    <= field_idx_reg + 5'h01;
              id_valid_reg <= 1'b1;
            end
          end
          default: begin
            kind_reg <= K_IDLE;
          end
        endcase
      end
    end
  end

  // Read-back driver, updated on falling bit clock edges.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_active_reg   <= 1'b0;
      cmd_read_o      <= 1'b0;
      cmd_read_oe_n_o <= 1'b1;
      dq_reg          <= 8'h00;
    end else if (kind_reg == K_IDLE || kind_reg == K_AUDIO
                 || kind_reg == K_IDSLOT) begin
      rd_active_reg   <= 1'b0;
      cmd_read_oe_n_o <= 1'b1;
      cmd_read_o      <= 1'b0;
    end else if (bck_fall) begin
      if (bit_cnt_reg == `RD_ENABLE_BIT) begin
        if ((kind_reg == K_EXT || !sr_reg[14]) && sr_reg[6]
            && is_sel(sr_reg[12], sr_reg[11:7], sr_reg[6],
                      my_id_reg, id_valid_reg)) begin
          rd_active_reg   <= 1'b1;
          cmd_read_oe_n_o <= 1'b0;
          cmd_read_o      <= 1'b0;
        end
      end else if (bit_cnt_reg == `RD_FIRST_BIT && rd_active_reg) begin
        {cmd_read_o, dq_reg[7:1]} <= read_mux(reg_addr_o,
                                              chan_ctrl_o, my_id_reg,
                                              reg_rdata_i);
        dq_reg[0] <= 1'b0;
      end else if (bit_cnt_reg > `RD_FIRST_BIT
                   && bit_cnt_reg <= `RD_LAST_BIT && rd_active_reg) begin
        cmd_read_o <= dq_reg[7];
        dq_reg     <= {dq_reg[6:0], 1'b0};
      end else if (bit_cnt_reg == `RD_RELEASE_BIT) begin
        rd_active_reg   <= 1'b0;
        cmd_read_oe_n_o <= 1'b1;
        cmd_read_o      <= 1'b0;
      end
    end
  end

  // Chain token: slot marker in ID frames, last channel or pass-through.
  always @* begin
    tok_next = 1'b0;
    if (shared_mode_o) begin
      if (kind_reg == K_IDSLOT) begin
        tok_next = id_valid_reg && (field_idx_reg == my_id_reg);
      end else if (!chans_on) begin
        tok_next = tok_s;
      end else begin
        tok_next = (kind_reg == K_AUDIO) && mine_reg && ch_idx_reg;
      end
    end
  end

  // Registered token and ID view.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chain_token_out_o <= 1'b0;
      chain_id_o        <= 8'h00;
    end else begin
      chain_token_out_o <= tok_next;
      chain_id_o        <= {3'h0, my_id_reg};
    end
  end

endmodule // tdm_command_audio_port

// ### tb/tdm_port_props.sv
/*
  Checker for the shared-frame audio port, bound to its top module.
  Assumes a bit clock of eight reference cycles per period.
*/
`timescale 1ns/1ps
module tdm_port_props (
  input wire logic       ref_clk_i,         // Reference clock.
  input wire logic       arst_n_i,          // Reset, active low.
  input wire logic       bit_clock_i,       // Raw bit clock.
  input wire logic       chain_token_in_i,  // Token from upstream.
  input wire logic       cmd_read_o,        // Read-back data.
  input wire logic       cmd_read_oe_n_o,   // Driver on while low.
  input wire logic       chain_token_out_o, // Token downstream.
  input wire logic       shared_mode_o,     // Shared-frame mode.
  input wire logic       audio_valid_o,     // Sample pair pulse.
  input wire logic       reg_wr_o,          // Register write pulse.
  input wire logic [6:0] reg_addr_o,        // Register identifier.
  input wire logic [7:0] chan_ctrl_o,       // Channel enable register.
  input wire logic [7:0] chain_id_o         // Acquired chain ID.
);
  logic [2:0] bck_sr;
  logic [3:0] since_rise;
  logic [3:0] since_fall;
  logic [7:0] low_cnt;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Counts up and stops at its top value.
  function automatic logic [3:0] sat(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  // Own bit clock synchroniser; ages of its edges and of the driver.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bck_sr     <= 3'h0;
      since_rise <= 4'hf;
      since_fall <= 4'hf;
      low_cnt    <= 8'h00;
    end else begin
      bck_sr     <= {bck_sr[1:0], bit_clock_i};
      since_rise <= (bck_sr[1] & ~bck_sr[2]) ? 4'h0 : sat(since_rise);
      since_fall <= (~bck_sr[1] & bck_sr[2]) ? 4'h0 : sat(since_fall);
      low_cnt    <= cmd_read_oe_n_o ? 8'h00 : low_cnt + 8'h01;
    end
  end

  chk_read_span: assert property ($rose(cmd_read_oe_n_o) |->
    low_cnt >= 8'h46 && low_cnt <= 8'h4a)
    else $error("read driver window is not nine bit periods");
  chk_drive_mode: assert property (!cmd_read_oe_n_o |->
    shared_mode_o) else $error("read line driven outside shared mode");
  chk_out_on_fall: assert property ($changed(cmd_read_o) |->
    since_fall <= 4'h6) else $error("read data moved away from a fall");
  chk_mode_entry: assert property ($changed(shared_mode_o) |->
    since_rise <= 4'h6) else $error("mode changed away from a rise");
  chk_ctrl_update: assert property ($changed(chan_ctrl_o) |->
    since_rise <= 4'h6) else $error("channel register moved off a rise");
  chk_id_legal: assert property (chain_id_o <= 8'h1e)
    else $error("chain ID out of range");
  chk_wr_addr: assert property (reg_wr_o |->
    reg_addr_o != 7'h13 && reg_addr_o != 7'h17 ##1 !reg_wr_o)
    else $error("bad external write pulse");
  chk_valid_pulse: assert property (audio_valid_o |=>
    !audio_valid_o) else $error("sample strobe longer than one cycle");
  chk_token_pass: assert property (chan_ctrl_o[0] && shared_mode_o &&
    $rose(chain_token_in_i) |-> ##[1:8] chain_token_out_o)
    else $error("token not passed through");
endmodule // tdm_port_props

bind tdm_command_audio_port tdm_port_props tdm_port_props_i (
  .ref_clk_i, .arst_n_i, .bit_clock_i, .chain_token_in_i, .cmd_read_o,
  .cmd_read_oe_n_o, .chain_token_out_o, .shared_mode_o, .audio_valid_o,
  .reg_wr_o, .reg_addr_o, .chan_ctrl_o, .chain_id_o
);

// ### tb/tdm_host_model.sv
/*
  Host and upstream chain device: sends frames of 32-bit fields, drives
  the upstream token and captures read-back of the command field.
  Assumes the bench loads fields and token levels before each frame.
*/
`timescale 1ns/1ps
module tdm_host_model (
  input  wire logic cmd_read_i,      // Read-back data from the port.
  input  wire logic cmd_read_oe_n_i, // Low while the port drives.
  input  wire logic token_out_i,     // Token from the port.
  output logic      bit_clock_o,     // Bit clock, still between frames.
  output logic      frame_sync_o,    // Frame sync.
  output logic      serial_o,        // Fields, MSB first.
  output logic      token_o          // Token into the port.
);
  logic [31:0] fw [4];
  logic [3:0]  tok;
  logic [31:0] rx;
  logic [3:0]  tok_seen;
  int          sync_len;
  // A released read line shows the inverse of the port's data output, which the port holds low, so it reads high.
  wire         do_line = cmd_read_oe_n_i ? ~cmd_read_i : cmd_read_i;

  // Idle levels at time zero.
  initial begin
    bit_clock_o = 1'b0;
    frame_sync_o = 1'b0;
    serial_o = 1'b0;
    token_o = 1'b0;
    tok = 4'h0;
    sync_len = 2;
  end

  // One frame; data, sync and token change while the clock is low.
  task automatic send(input int n);
    rx = 32'h0;
    tok_seen = 4'h0;
    for (int f = 0; f < n; f++) begin
      for (int b = 31; b >= 0; b--) begin
        serial_o = fw[f][b];
        frame_sync_o = (f == 0) && (b > 31 - sync_len);
        token_o = tok[f];
        #100 bit_clock_o = 1'b1;
        if (f == 0) rx = {rx[30:0], do_line};
        // Token out is taken on the rise, as the next device takes it;
        // the host itself never acts on it.
        tok_seen[f] = tok_seen[f] | token_out_i;
        #100 bit_clock_o = 1'b0;
      end
    end
    frame_sync_o = 1'b0;
    #1000;
  endtask
endmodule // tdm_host_model

// ### tb/tb_tdm_command_audio_port.sv
/*
  Self-checking bench for the shared-frame audio port.
  Assumes the host model owns all link timing.
*/
`timescale 1ns/1ps
`define CHECK_EQ(a, b) begin tests_run++; if ((a) !== (b)) begin \
  errors++; $display("CHECK FAILED t=%0t %h != %h", $time, a, b); end end
module tb_tdm_command_audio_port;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  wire         bit_clock, sync, sdi, tok_in, do_q, oe_n, tok_out, mode, aval, wr;
  wire  [23:0] left, right;
  wire  [6:0]  addr;
  wire  [7:0]  wdata, ctrl, cid;
  logic [14:0] last_wr;
  int          errors = 0, tests_run = 0, wr_cnt = 0, av_cnt = 0, oe_cnt;
  int          n0;
  wire  [31:0] rx = tdm_host_model_i.rx;
  wire  [3:0]  seen = tdm_host_model_i.tok_seen;

  tdm_command_audio_port tdm_command_audio_port_i (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .frame_sync_i(sync),
    .bit_clock_i(bit_clock), .frame_serial_in_i(sdi), .chain_token_in_i(tok_in),
    .reg_rdata_i(8'hc3), .cmd_read_o(do_q), .cmd_read_oe_n_o(oe_n),
    .chain_token_out_o(tok_out), .shared_mode_o(mode),
    .audio_left_o(left), .audio_right_o(right), .audio_valid_o(aval),
    .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .chan_ctrl_o(ctrl), .chain_id_o(cid));
  tdm_host_model tdm_host_model_i (
    .cmd_read_i(do_q), .cmd_read_oe_n_i(oe_n), .token_out_i(tok_out),
    .bit_clock_o(bit_clock), .frame_sync_o(sync), .serial_o(sdi),
    .token_o(tok_in));

  // Reference clock.
  always #12.5 ref_clk = ~ref_clk;

  // Counts pulses and driver-on cycles at the ports.
  always @(posedge ref_clk) begin
    wr_cnt += (wr === 1'b1);
    av_cnt += (aval === 1'b1);
    oe_cnt += (oe_n === 1'b0);
    if (wr === 1'b1) last_wr = {addr, wdata};
  end

  // Command word: flags {assign, extended, chain select}.
  function automatic logic [31:0] cmd(input logic [2:0] f,
      input logic [4:0] id, input logic rd, input logic [6:0] ra,
      input logic [7:0] d);
    return {f, id, rd, ra, d, 8'h00};
  endfunction

  // Loads one frame into the host and sends it.
  task automatic frame(input int n, input logic [3:0] t,
      input logic [31:0] w0, w1 = 0, w2 = 0, w3 = 0);
    @(posedge ref_clk);
    #2;
    tdm_host_model_i.fw = '{w0, w1, w2, w3};
    tdm_host_model_i.tok = t;
    tdm_host_model_i.send(n);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run time.
  initial begin
    #2000000;
    errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    logic [31:0] wc [5];
    logic [7:0]  we [5];
    wc = '{cmd(0, 1, 0, 7'h13, 8'h5a), cmd(0, 0, 0, 7'h13, 8'hff),
           cmd(0, 2, 0, 7'h13, 8'hff), cmd(1, 1, 0, 7'h13, 8'hff),
           cmd(0, 5'h1f, 0, 7'h13, 8'h3c)};
    we = '{8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h3c};
    repeat (3) @(posedge ref_clk);
    #2;
    arst_n = 1'b1;
    `CHECK_EQ(oe_n, 1'b1)
    `CHECK_EQ(ctrl, 8'h00)
    tdm_host_model_i.sync_len = 16;
    frame(1, 4'h0, 32'h0);
    `CHECK_EQ(mode, 1'b0)
    tdm_host_model_i.sync_len = 2;
    frame(1, 4'h0, 32'h0);
    frame(1, 4'h0, 32'h0);
    `CHECK_EQ(mode, 1'b1)
    frame(4, 4'b0010, cmd(3'b110, 1, 0, 7'h13, 8'hff));
    `CHECK_EQ(cid, 8'h02)
    frame(4, 4'hf, cmd(3'b100, 2, 0, 7'h13, 8'hff));
    `CHECK_EQ(cid, 8'h01)
    `CHECK_EQ(ctrl, 8'h00)
    for (int i = 0; i < 5; i++) begin
      frame(1, 4'hf, wc[i]);
      `CHECK_EQ(ctrl, we[i])
    end
    frame(1, 4'hf, cmd(0, 1, 0, 7'h05, 8'ha7));
    `CHECK_EQ(wr_cnt, 1)
    `CHECK_EQ(last_wr, {7'h05, 8'ha7})
    frame(1, 4'hf, cmd(0, 1, 0, 7'h17, 8'h09));
    `CHECK_EQ(wr_cnt, 1)
    `CHECK_EQ(cid, 8'h01)
    frame(1, 4'hf, cmd(0, 1, 1, 7'h13, 8'h00));
    `CHECK_EQ(rx[15:8], 8'h3c)
    frame(1, 4'hf, cmd(0, 1, 1, 7'h05, 8'h00));
    `CHECK_EQ(rx[15:8], 8'hc3)
    frame(1, 4'hf, cmd(0, 1, 1, 7'h17, 8'h00));
    `CHECK_EQ(rx[15:8], 8'h01)
    n0 = oe_cnt;
    frame(1, 4'hf, cmd(0, 5'h1f, 1, 7'h13, 8'h00));
    `CHECK_EQ(oe_cnt, n0)
    n0 = av_cnt;
    frame(3, 4'hf, cmd(3'b010, 2, 0, 7'h13, 8'hff),
          cmd(3'b100, 1, 0, 7'h13, 8'h66), 32'h7777_7700);
    `CHECK_EQ(ctrl, 8'h66)
    `CHECK_EQ(av_cnt, n0)
    frame(4, 4'b0001, 32'h0, 32'h1234_5600, 32'habcd_ef00);
    `CHECK_EQ(left, 24'h12_3456)
    `CHECK_EQ(right, 24'hab_cdef)
    `CHECK_EQ(av_cnt, n0 + 1)
    `CHECK_EQ(seen[2:1], 2'b10)
    frame(1, 4'hf, cmd(0, 1, 0, 7'h13, 8'h01));
    n0 = av_cnt;
    frame(4, 4'b0010, 32'h0, 32'h1111_1100, 32'h2222_2200);
    `CHECK_EQ(seen[2:0], 3'b010)
    `CHECK_EQ(av_cnt, n0)
    summarize();
  end
endmodule // tb_tdm_command_audio_port
